// ---- hw/nvmc_defs.vh ----
// Purpose: constants for the nvm program/erase control block
// Assumes: axi4-lite register map, 32-bit words, byte addresses
// Notes:   times in ns, counts derived for a 4 ns bus clock
`ifndef NVMC_DEFS_VH
`define NVMC_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define NVMC_OFF_FLASH_CTRL   8'h00
`define NVMC_OFF_EE_CTRL      8'h04
`define NVMC_OFF_DIV_HIGH     8'h08
`define NVMC_OFF_DIV_LOW      8'h0c
`define NVMC_OFF_STATUS       8'h10
`define NVMC_OFF_IRQ_STAT     8'h14
`define NVMC_OFF_IRQ_MASK     8'h18
`define NVMC_OFF_ROW_ADDR     8'h1c
`define NVMC_OFF_EE_ADDR      8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NVMC_FL_PGM_BIT       0
`define NVMC_FL_ERASE_BIT     1
`define NVMC_EE_PULSE_BIT     0
`define NVMC_EE_ERASE_BIT     2
`define NVMC_EE_SELF_BIT      5
`define NVMC_ST_FL_BUSY       0
`define NVMC_ST_EE_BUSY       1
`define NVMC_ST_WR_LIMIT      2
`define NVMC_IRQ_FL_DONE      0
`define NVMC_IRQ_EE_DONE      1
`define NVMC_IRQ_WR_LIMIT     2

// ----------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------
`define NVMC_ROW_BYTES        64
`define NVMC_DIV_W            10
`define NVMC_DIV_HIGH_W       2
`define NVMC_DIV_LOW_W        8
`define NVMC_MAX_WRITES       8
`define NVMC_CLK_NS           4
`define NVMC_FL_PGM_NS        20000
`define NVMC_FL_ERASE_NS      100000
`define NVMC_FL_PGM_CYC       ((`NVMC_FL_PGM_NS + `NVMC_CLK_NS - 1) / `NVMC_CLK_NS)
`define NVMC_FL_ERASE_CYC     ((`NVMC_FL_ERASE_NS + `NVMC_CLK_NS - 1) / `NVMC_CLK_NS)
`define NVMC_EE_PGM_TICKS     16'd10
`define NVMC_EE_ERASE_TICKS   16'd20

`endif

// ---- hw/nvmc_sync2.v ----
// Purpose: two-flop synchroniser for one level
// Assumes: input is asynchronous to clk
// Notes:   first flop read only by the second
`timescale 1ns/1ps
`default_nettype none

module nvmc_sync2
(
  input  wire clk,
  input  wire rst,
  input  wire d,
  output wire q
);

  reg meta_r;
  reg sync_r;

  // ----------------------------------------------------------------
  // two-stage capture
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule // nvmc_sync2
`default_nettype wire

// ---- hw/nvmc_timer.v ----
// Purpose: down counter for a fixed operation duration
// Assumes: tick marks one unit of time
// Notes:   done pulses once when the count runs out
`timescale 1ns/1ps
`default_nettype none

module nvmc_timer #(
  parameter W = 16
)
(
  input  wire         clk,
  input  wire         rst,
  input  wire         start,
  input  wire         abort,
  input  wire         tick,
  input  wire [W-1:0] count,
  output wire         busy,
  output reg          done
);

  reg [W-1:0] cnt_r;
  reg         busy_r;

  // ----------------------------------------------------------------
  // count down on ticks
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r  <= {W{1'b0}};
      busy_r <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
        busy_r <= 1'b0;
      else if (start)
      begin
        cnt_r  <= count;
        busy_r <= 1'b1;
      end
      else if (busy_r && tick)
      begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1})
        begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end
        else
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign busy = busy_r;

endmodule // nvmc_timer
`default_nettype wire

// ---- hw/nvmc_ctrl.v ----
// Purpose: flash and eeprom program/erase control with axi4-lite registers
// Assumes: sys_clk 250 MHz, crystal_clock_input asynchronous, shadow word static
// Notes:   array cells are outside; this block sequences and times operations
//
// Functional notes
// - flash programming writes a whole 64-byte row per operation.
// - flash erase clears the whole array, with no sector erase.
// - flash program and erase each last a fixed internal time, no re-pulse loop.
// - the eeprom divider counts crystal clock edges, not the bus clock.
// - a 10-bit divide ratio split over high and low registers sets the eeprom time base.
// - the divider registers reload from the shadow word on every reset.
// - eeprom program control bit 5 enables self-timed operation.
// - in self-timed mode the device times the operation itself.
// - in self-timed mode hardware clears the program pulse bit when done.
// - up to eight program writes to one eeprom byte precede one erase.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_defs.vh"

module nvmc_ctrl #(
  parameter FL_PGM_CYC   = `NVMC_FL_PGM_CYC,
  parameter FL_ERASE_CYC = `NVMC_FL_ERASE_CYC
)
(
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        crystal_clock_input,
  input  wire [9:0]  shadow_divider,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // array strobes
  output reg         flash_row_program,
  output reg         flash_bulk_erase,
  output reg  [15:0] flash_row_addr,
  output reg         eeprom_high_voltage,
  output reg         eeprom_erase_mode,
  output reg  [15:0] eeprom_byte_addr,
  output wire        irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [1:0]  flash_program_control_r;
  reg [7:0]  eeprom_program_control_r;
  reg [1:0]  timebase_divider_high_r;
  reg [7:0]  timebase_divider_low_r;
  reg [2:0]  irq_stat_r;
  reg [2:0]  irq_mask_r;
  reg [15:0] row_addr_r;
  reg [15:0] ee_addr_r;
  reg [3:0]  write_count_r;
  reg [15:0] track_addr_r;
  reg        aw_held_r;
  reg        w_held_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  reg        shadow_load_r;
  reg [9:0]  pre_cnt_r;
  reg        xtal_d_r;
  reg        ee_tick_r;
  reg        ee_pulse_d_r;

  wire       xtal_s;
  wire       fl_busy;
  wire       fl_done;
  wire       ee_busy;
  wire       ee_done;
  wire [9:0] div_ratio;
  wire       wr_go;
  wire       rd_go;
  wire       ee_pulse;
  wire       ee_self;
  wire       ee_erase;
  wire       ee_start;
  wire       fl_pgm_start;
  wire       fl_erase_start;
  wire       at_limit;

  // ----------------------------------------------------------------
  // crystal clock crossing and prescaler
  // ----------------------------------------------------------------
  nvmc_sync2 u_xtal_sync
  (
    .clk (sys_clk),
    .rst (rst),
    .d   (crystal_clock_input),
    .q   (xtal_s)
  );

  assign div_ratio = {timebase_divider_high_r, timebase_divider_low_r};

  // one tick per div_ratio+1 crystal rising edges
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      xtal_d_r  <= 1'b0;
      pre_cnt_r <= 10'h000;
      ee_tick_r <= 1'b0;
    end
    else
    begin
      xtal_d_r  <= xtal_s;
      ee_tick_r <= 1'b0;
      if (xtal_s && !xtal_d_r)
      begin
        if (pre_cnt_r >= div_ratio)
        begin
          pre_cnt_r <= 10'h000;
          ee_tick_r <= 1'b1;
        end
        else
          pre_cnt_r <= pre_cnt_r + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // operation timers
  // ----------------------------------------------------------------
  assign ee_pulse       = eeprom_program_control_r[`NVMC_EE_PULSE_BIT];
  assign ee_self        = eeprom_program_control_r[`NVMC_EE_SELF_BIT];
  assign ee_erase       = eeprom_program_control_r[`NVMC_EE_ERASE_BIT];
  assign ee_start       = ee_pulse && !ee_pulse_d_r && ee_self;
  assign at_limit       = (write_count_r >= `NVMC_MAX_WRITES);
  assign fl_pgm_start   = wr_go && (aw_addr_r == `NVMC_OFF_FLASH_CTRL) && w_strb_r[0]
                          && w_data_r[`NVMC_FL_PGM_BIT] && !fl_busy;
  assign fl_erase_start = wr_go && (aw_addr_r == `NVMC_OFF_FLASH_CTRL) && w_strb_r[0]
                          && w_data_r[`NVMC_FL_ERASE_BIT] && !w_data_r[`NVMC_FL_PGM_BIT]
                          && !fl_busy;

  // flash times are fixed cycle counts, no software in the loop
  nvmc_timer #(.W(32)) u_fl_timer
  (
    .clk   (sys_clk),
    .rst   (rst),
    .start (fl_pgm_start || fl_erase_start),
    .abort (1'b0),
    .tick  (1'b1),
    .count (fl_pgm_start ? FL_PGM_CYC : FL_ERASE_CYC),
    .busy  (fl_busy),
    .done  (fl_done)
  );

  // eeprom timer counts prescaler ticks
  nvmc_timer #(.W(16)) u_ee_timer
  (
    .clk   (sys_clk),
    .rst   (rst),
    .start (ee_start),
    .abort (!ee_pulse),
    .tick  (ee_tick_r),
    .count (ee_erase ? `NVMC_EE_ERASE_TICKS : `NVMC_EE_PGM_TICKS),
    .busy  (ee_busy),
    .done  (ee_done)
  );

  // ----------------------------------------------------------------
  // array strobes
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flash_row_program   <= 1'b0;
      flash_bulk_erase    <= 1'b0;
      flash_row_addr      <= 16'h0000;
      eeprom_high_voltage <= 1'b0;
      eeprom_erase_mode   <= 1'b0;
      eeprom_byte_addr    <= 16'h0000;
    end
    else
    begin
      flash_row_program   <= fl_busy && flash_program_control_r[`NVMC_FL_PGM_BIT];
      flash_bulk_erase    <= fl_busy && flash_program_control_r[`NVMC_FL_ERASE_BIT];
      flash_row_addr      <= row_addr_r & ~(16'd`NVMC_ROW_BYTES - 16'd1);
      eeprom_high_voltage <= ee_pulse && (ee_erase || !at_limit);
      eeprom_erase_mode   <= ee_erase;
      eeprom_byte_addr    <= ee_addr_r;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;

  // capture address and data in either order
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r <= `NVMC_OFF_EE_ADDR && aw_addr_r[1:0] == 2'b00
                         && aw_addr_r != `NVMC_OFF_STATUS) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register writes, shadow reload, hardware clears
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flash_program_control_r  <= 2'b00;
      eeprom_program_control_r <= 8'h00;
      timebase_divider_high_r  <= 2'b00;
      timebase_divider_low_r   <= 8'h00;
      irq_mask_r               <= 3'b000;
      row_addr_r               <= 16'h0000;
      ee_addr_r                <= 16'h0000;
      shadow_load_r            <= 1'b1;
      ee_pulse_d_r             <= 1'b0;
    end
    else
    begin
      ee_pulse_d_r  <= ee_pulse;
      shadow_load_r <= 1'b0;
      if (shadow_load_r)
      begin
        timebase_divider_high_r <= shadow_divider[9:8];
        timebase_divider_low_r  <= shadow_divider[7:0];
      end
      if (fl_done)
        flash_program_control_r <= 2'b00;
      if (wr_go && w_strb_r[0])
      begin
        case (aw_addr_r)
          `NVMC_OFF_FLASH_CTRL: if (!fl_busy) // program wins over erase
            flash_program_control_r <= {w_data_r[1] & ~w_data_r[0], w_data_r[0]};
          `NVMC_OFF_EE_CTRL:    eeprom_program_control_r <= w_data_r[7:0] & 8'h25;
          `NVMC_OFF_DIV_HIGH:   timebase_divider_high_r <= w_data_r[1:0];
          `NVMC_OFF_DIV_LOW:    timebase_divider_low_r <= w_data_r[7:0];
          `NVMC_OFF_IRQ_MASK:   irq_mask_r <= w_data_r[2:0];
          `NVMC_OFF_ROW_ADDR:   row_addr_r[7:0] <= w_data_r[7:0];
          `NVMC_OFF_EE_ADDR:    ee_addr_r[7:0] <= w_data_r[7:0];
          default: ;
        endcase
      end
      if (wr_go && w_strb_r[1])
      begin
        if (aw_addr_r == `NVMC_OFF_ROW_ADDR)
          row_addr_r[15:8] <= w_data_r[15:8];
        if (aw_addr_r == `NVMC_OFF_EE_ADDR)
          ee_addr_r[15:8] <= w_data_r[15:8];
      end
      // hardware clear wins over a same-cycle software write
      if (ee_done && ee_self)
        eeprom_program_control_r[`NVMC_EE_PULSE_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // selective write tracking for the last addressed byte
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      write_count_r <= 4'h0;
      track_addr_r  <= 16'h0000;
    end
    else if (ee_pulse && !ee_pulse_d_r)
    begin
      if (ee_erase)
        write_count_r <= 4'h0;
      else if (ee_addr_r != track_addr_r)
      begin
        track_addr_r  <= ee_addr_r;
        write_count_r <= 4'h1;
      end
      else if (!at_limit)
        write_count_r <= write_count_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, read clears, set wins
  // ----------------------------------------------------------------
  wire [2:0] irq_set;
  wire       stat_rd;
  assign irq_set = {(ee_pulse && !ee_pulse_d_r && !ee_erase && at_limit), ee_done, fl_done};
  assign stat_rd = rd_go && (s_axi_araddr == `NVMC_OFF_IRQ_STAT);

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_stat_r <= 3'b000;
    else
      irq_stat_r <= irq_set | (stat_rd ? 3'b000 : irq_stat_r);
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `NVMC_OFF_FLASH_CTRL: s_axi_rdata <= {30'h0, flash_program_control_r};
        `NVMC_OFF_EE_CTRL:    s_axi_rdata <= {24'h0, eeprom_program_control_r};
        `NVMC_OFF_DIV_HIGH:   s_axi_rdata <= {30'h0, timebase_divider_high_r};
        `NVMC_OFF_DIV_LOW:    s_axi_rdata <= {24'h0, timebase_divider_low_r};
        `NVMC_OFF_STATUS:     s_axi_rdata <= {25'h0, write_count_r, at_limit, ee_busy, fl_busy};
        `NVMC_OFF_IRQ_STAT:   s_axi_rdata <= {29'h0, irq_stat_r};
        `NVMC_OFF_IRQ_MASK:   s_axi_rdata <= {29'h0, irq_mask_r};
        `NVMC_OFF_ROW_ADDR:   s_axi_rdata <= {16'h0, row_addr_r};
        `NVMC_OFF_EE_ADDR:    s_axi_rdata <= {16'h0, ee_addr_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // nvmc_ctrl
`default_nettype wire

// ---- verif/nvmc_ctrl_properties.sv ----
// Purpose: port-level checks for nvmc_ctrl
// Assumes: one clock, async active-high reset, bench master
// Notes:   flash durations checked by a run-length counter
`timescale 1ns/1ps
`default_nettype none

module nvmc_ctrl_properties #(
  parameter FL_PGM_CYC   = 20,
  parameter FL_ERASE_CYC = 40
)
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        flash_row_program,
  input wire logic        flash_bulk_erase,
  input wire logic [15:0] flash_row_addr,
  input wire logic        eeprom_high_voltage,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  reg [15:0] run_r;

  // cycles spent in the current flash operation
  always @(posedge sys_clk or posedge rst)
    if (rst)
      run_r <= 16'h0000;
    else if (flash_row_program || flash_bulk_erase)
      run_r <= run_r + 16'h0001;
    else
      run_r <= 16'h0000;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_row_align: assert property (flash_row_addr[5:0] == 6'h00)
    else $error("row address not on a row boundary");
  a_one_flash_op: assert property (!(flash_row_program && flash_bulk_erase))
    else $error("program and erase together");
  a_pgm_fixed: assert property ($fell(flash_row_program) |->
    (run_r >= FL_PGM_CYC - 1) && (run_r <= FL_PGM_CYC + 2))
    else $error("row program length wrong");
  a_erase_fixed: assert property ($fell(flash_bulk_erase) |->
    (run_r >= FL_ERASE_CYC - 1) && (run_r <= FL_ERASE_CYC + 2))
    else $error("bulk erase length wrong");
  a_wr_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");

  c_pgm: cover property ($rose(flash_row_program));
  c_erase: cover property ($rose(flash_bulk_erase));
  c_hv_end: cover property ($fell(eeprom_high_voltage));
  c_irq: cover property ($rose(irq));
endmodule // nvmc_ctrl_properties

bind nvmc_ctrl nvmc_ctrl_properties #(.FL_PGM_CYC(FL_PGM_CYC), .FL_ERASE_CYC(FL_ERASE_CYC))
  u_props (.sys_clk, .rst, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .flash_row_program, .flash_bulk_erase, .flash_row_addr,
  .eeprom_high_voltage, .irq);

`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for nvmc_ctrl over axi4-lite
// Assumes: crystal made here at a quarter of the bus rate
// Notes:   short flash times passed as parameters
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_defs.vh"

module testbench;
  localparam [7:0] A_FC = `NVMC_OFF_FLASH_CTRL;
  localparam [7:0] A_EC = `NVMC_OFF_EE_CTRL;
  localparam [7:0] A_DH = `NVMC_OFF_DIV_HIGH;
  localparam [7:0] A_DL = `NVMC_OFF_DIV_LOW;
  localparam [7:0] A_ST = `NVMC_OFF_STATUS;
  localparam [7:0] A_IS = `NVMC_OFF_IRQ_STAT;
  localparam [7:0] A_IM = `NVMC_OFF_IRQ_MASK;
  reg         sys_clk = 1'b0, rst = 1'b1, crystal_clock_input = 1'b0;
  reg  [9:0]  shadow_divider = 10'h155;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        flash_row_program, flash_bulk_erase, eeprom_high_voltage, eeprom_erase_mode, irq;
  wire [15:0] flash_row_addr, eeprom_byte_addr;
  integer     bad_count = 0, samples_checked = 0, xt = 0, i, n, e;
  reg  [31:0] rd_v, ctl;
  reg  [1:0]  rr;

  nvmc_ctrl #(.FL_PGM_CYC(20), .FL_ERASE_CYC(40)) dut (.sys_clk, .rst, .crystal_clock_input,
    .shadow_divider, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_row_program, .flash_bulk_erase,
    .flash_row_addr, .eeprom_high_voltage, .eeprom_erase_mode, .eeprom_byte_addr, .irq);

  // bus clock and a crystal at a quarter of its rate
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    xt <= xt + 1;
    if (xt[0])
      crystal_clock_input <= ~crystal_clock_input;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // write; response ready raised late to stall once
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ad, wd;
    begin
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      while (!(ad && wd))
      begin
        @(negedge sys_clk);
        if (s_axi_awvalid && s_axi_awready)
          ad = 1'b1;
        if (s_axi_wvalid && s_axi_wready)
          wd = 1'b1;
        @(posedge sys_clk);
        if (ad)
          s_axi_awvalid <= 1'b0;
        if (wd)
          s_axi_wvalid <= 1'b0;
      end
      @(negedge sys_clk);
      while (s_axi_bvalid !== 1'b1)
        @(negedge sys_clk);
      @(posedge sys_clk);
      s_axi_bready <= 1'b1;
      @(negedge sys_clk);
      chk(s_axi_bresp, er);
      @(posedge sys_clk);
      s_axi_bready <= 1'b0;
    end
  endtask

  // read into rd_v and rr; data ready raised late
  task rd(input [7:0] a);
    begin
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(negedge sys_clk);
      while (s_axi_arready !== 1'b1)
        @(negedge sys_clk);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      @(negedge sys_clk);
      while (s_axi_rvalid !== 1'b1)
        @(negedge sys_clk);
      @(posedge sys_clk);
      s_axi_rready <= 1'b1;
      @(negedge sys_clk);
      rd_v = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
    end
  endtask

  task rc(input [7:0] a, input [31:0] exp, input [1:0] er);
    begin
      rd(a);
      chk(rd_v, exp);
      chk(rr, er);
    end
  endtask

  // poll a bit until it clears, bounded
  task poll(input [7:0] a, input integer b);
    begin
      n = 0;
      rd(a);
      while (rd_v[b] && n < 500)
      begin
        rd(a);
        n = n + 1;
      end
      chk(rd_v[b], 1'b0);
    end
  endtask

  task do_reset(input [9:0] sh);
    begin
      @(posedge sys_clk);
      rst <= 1'b1;
      shadow_divider <= sh;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    close_out;
  end

  initial
  begin
    do_reset(10'h155);
    rc(A_DH, 32'h1, 2'b00);
    rc(A_DL, 32'h55, 2'b00);
    rc(A_EC, 32'h0, 2'b00);
    rc(A_IM, 32'h0, 2'b00);
    wr(A_DL, 32'h0a, 2'b00);
    rc(A_DL, 32'h0a, 2'b00);
    do_reset(10'h2c3);
    rc(A_DH, 32'h2, 2'b00);
    rc(A_DL, 32'hc3, 2'b00);
    $display("test reset load done");
    wr(8'h40, 32'h1, 2'b10);
    rc(8'h40, 32'h0, 2'b10);
    wr(8'h02, 32'h1, 2'b10);
    wr(A_ST, 32'h0, 2'b10);
    $display("test bus errors done");
    wr(A_IM, 32'h7, 2'b00);
    wr(`NVMC_OFF_ROW_ADDR, 32'h1234, 2'b00);
    wr(A_FC, 32'h3, 2'b00);
    chk({flash_row_program, flash_bulk_erase}, 2'b10);
    chk(flash_row_addr, 16'h1200);
    wr(A_FC, 32'h2, 2'b00);
    poll(A_ST, `NVMC_ST_FL_BUSY);
    chk(flash_bulk_erase, 1'b0);
    chk(irq, 1'b1);
    rc(A_IS, 32'h1, 2'b00);
    chk(irq, 1'b0);
    rc(A_FC, 32'h0, 2'b00);
    wr(A_FC, 32'h2, 2'b00);
    chk({flash_row_program, flash_bulk_erase}, 2'b01);
    poll(A_ST, `NVMC_ST_FL_BUSY);
    rc(A_IS, 32'h1, 2'b00);
    $display("test flash done");
    wr(A_IM, 32'h5, 2'b00);
    wr(`NVMC_OFF_EE_ADDR, 32'h5, 2'b00);
    wr(A_DH, 32'h0, 2'b00);
    for (i = 0; i < 3; i = i + 1)
    begin
      ctl = (i == 2) ? 32'h25 : 32'h21;
      e = ((i == 2) ? 20 : 10) * ((i == 1) ? 4 : 2) * 4;
      wr(A_DL, (i == 1) ? 32'h3 : 32'h1, 2'b00);
      wr(A_EC, ctl, 2'b00);
      chk({eeprom_high_voltage, eeprom_erase_mode}, {1'b1, ctl[2]});
      n = 0;
      while (eeprom_high_voltage === 1'b1 && n < 2000)
      begin
        @(negedge sys_clk);
        n = n + 1;
      end
      chk((n >= e - 24) && (n <= e + 8), 1'b1);
      rc(A_EC, ctl & 32'hfe, 2'b00);
      chk(irq, 1'b0);
      rc(A_IS, 32'h2, 2'b00);
      rc(A_IS, 32'h0, 2'b00);
    end
    $display("test eeprom self-timed done");
    wr(A_EC, 32'h1, 2'b00);
    repeat (400) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(eeprom_high_voltage, 1'b1);
    rc(A_EC, 32'h1, 2'b00);
    wr(A_EC, 32'h0, 2'b00);
    chk(eeprom_high_voltage, 1'b0);
    wr(`NVMC_OFF_EE_ADDR, 32'h9, 2'b00);
    chk(eeprom_byte_addr, 16'h9);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(A_EC, 32'h1, 2'b00);
      wr(A_EC, 32'h0, 2'b00);
    end
    rc(A_ST, 32'h44, 2'b00);
    wr(A_EC, 32'h1, 2'b00);
    chk(eeprom_high_voltage, 1'b0);
    chk(irq, 1'b1);
    rc(A_IS, 32'h4, 2'b00);
    chk(irq, 1'b0);
    wr(A_EC, 32'h0, 2'b00);
    wr(A_EC, 32'h5, 2'b00);
    chk({eeprom_high_voltage, eeprom_erase_mode}, 2'b11);
    wr(A_EC, 32'h0, 2'b00);
    rc(A_ST, 32'h0, 2'b00);
    $display("test write limit done");
    close_out;
  end
endmodule // testbench

`default_nettype wire
